// ---- hw/standard_event_flags_regs.sv ----
// Purpose: event flags, enable mask and summary bit of a remote instrument
// Assumes: commands come parsed; error events are one-cycle pulses
// Notes:   replies are ascii decimal bytes ending in cr lf
`timescale 1ns/1ps

// How it works
// (R1) clear command zeroes every event flag bit
// (R2) clear command also drops the event summary bit of the status byte
// (R3) clear command discards pending error conditions
// (R4) mask write takes an operand 0..255 and stores it as 8-bit mask
// (R5) enable mask is zero after power-on
// (R6) any flag set with its mask bit one sets the event summary bit
// (R7) mask query answers with 1 to 3 decimal digits then cr lf
// (R8) flags query answers with 1 to 3 decimal digits then cr lf
// (R9) flags: power-on 7, cmd 5, exec 4, device 3, query 2, done 0
// (R10) mask bit positions match flag positions one to one
// (R11) operation-complete command sets done flag when operation finishes
// (R12) summary bit is or of flags anded with mask, at status bit 5
module sest_regs
  import sest_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_code,
  input  wire logic [7:0] cmd_operand,
  output logic            cmd_ready,
  input  wire logic       cmd_err_event,
  input  wire logic       exec_err_event,
  input  wire logic       dev_err_event,
  input  wire logic       query_err_event,
  input  wire logic       op_busy,
  output logic            reply_valid,
  output logic [7:0]      reply_data,
  input  wire logic       reply_ready,
  output logic [7:0]      event_enable_mask,
  output logic [7:0]      standard_event_flags,
  output logic [7:0]      status_summary_byte,
  output logic            error_pending
);

  sest_fmt_if  fmt_bus ();
  sest_state_t state;
  sest_state_t next_state;
  sest_cmd_t   code;
  logic        cmd_take;
  logic        clear_take;
  logic        op_done_set;
  logic        any_error;
  logic [7:0]  new_events;
  logic [7:0]  next_flags;
  logic [7:0]  next_mask;
  logic        fmt_start;
  logic [7:0]  fmt_value;

  assign code       = sest_cmd_t'(cmd_code);
  assign cmd_take   = cmd_valid && cmd_ready;
  assign clear_take = cmd_take && (code == SEST_CMD_CLEAR);
  assign any_error  = cmd_err_event || exec_err_event ||
                      dev_err_event || query_err_event;

  // done flag fires once the pending operation has drained
  assign op_done_set = (state == SEST_ST_WAIT) && !op_busy; // R11

  // event vector in flag order; bits 6 and 1 are never driven
  always_comb begin
    new_events                = 8'h00;
    new_events[CMD_ERR_BIT]   = cmd_err_event;   // R9
    new_events[EXEC_ERR_BIT]  = exec_err_event;  // R9
    new_events[DEV_ERR_BIT]   = dev_err_event;   // R9
    new_events[QUERY_ERR_BIT] = query_err_event; // R9
    new_events[OP_DONE_BIT]   = op_done_set;     // R11
  end

  // a clear in the same cycle as an event keeps the event
  assign next_flags = ((clear_take ? 8'h00 : standard_event_flags) // R1
                       | new_events) & FLAGS_LIVE_BITS;            // R9

  assign next_mask = (cmd_take && code == SEST_CMD_MASK_WR) ?
                     cmd_operand : event_enable_mask;              // R4

  // sequencer: one command at a time, replies and done-wait stall intake
  always_comb begin
    next_state = state;
    case (state)
      SEST_ST_IDLE: begin
        if (cmd_take) begin
          case (code)
            SEST_CMD_MASK_RD:  next_state = SEST_ST_REPLY; // R7
            SEST_CMD_FLAGS_RD: next_state = SEST_ST_REPLY; // R8
            SEST_CMD_OP_DONE:  next_state = SEST_ST_WAIT;  // R11
            default:           next_state = SEST_ST_IDLE;
          endcase
        end
      end
      SEST_ST_REPLY: begin
        if (!fmt_start && !fmt_bus.out_valid) begin
          next_state = SEST_ST_IDLE;
        end
      end
      SEST_ST_WAIT: begin
        if (!op_busy) begin
          next_state = SEST_ST_IDLE;
        end
      end
      default: next_state = SEST_ST_IDLE;
    endcase
  end

  // state and intake handshake
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= SEST_ST_IDLE;
      cmd_ready <= 1'b1;
    end else begin
      state     <= next_state;
      cmd_ready <= (next_state == SEST_ST_IDLE);
    end
  end

  // enable mask; positions line up with the flag positions
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      event_enable_mask <= MASK_RESET; // R5
    end else begin
      event_enable_mask <= next_mask;  // R4 R10
    end
  end

  // event flags; power-on is set by reset itself
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      standard_event_flags <= FLAGS_RESET; // R9
    end else begin
      standard_event_flags <= next_flags;  // R1
    end
  end

  // summary from next values so it never lags the flags it covers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_summary_byte <= 8'h00;
    end else begin
      status_summary_byte                <= 8'h00;
      status_summary_byte[EVENT_SUM_BIT] <=
        |(next_flags & next_mask); // R6 R12 R2
    end
  end

  // pending error conditions; new errors win over a clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      error_pending <= 1'b0;
    end else if (any_error) begin
      error_pending <= 1'b1;
    end else if (clear_take) begin
      error_pending <= 1'b0; // R3
    end
  end

  // query launch: the value is captured as the command is taken
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt_start <= 1'b0;
      fmt_value <= 8'h00;
    end else begin
      fmt_start <= cmd_take && (code == SEST_CMD_MASK_RD ||
                                code == SEST_CMD_FLAGS_RD);
      if (cmd_take && code == SEST_CMD_MASK_RD) begin
        fmt_value <= event_enable_mask;    // R7
      end else if (cmd_take && code == SEST_CMD_FLAGS_RD) begin
        fmt_value <= standard_event_flags; // R8
      end
    end
  end

  assign fmt_bus.start     = fmt_start;
  assign fmt_bus.value     = fmt_value;
  assign fmt_bus.out_ready = reply_ready;
  assign reply_valid       = fmt_bus.out_valid;
  assign reply_data        = fmt_bus.out_data;

  sest_dec_fmt u_fmt (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .fmt      (fmt_bus)
  );

  // helper: low only in the first cycle after reset release
  logic seen_edge;
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_edge <= 1'b0;
    end else begin
      seen_edge <= 1'b1;
    end
  end

  property p_clear_flags; // R1
    @(posedge core_clk) disable iff (!arst_n)
      (clear_take && !any_error && state == SEST_ST_IDLE)
      |=> standard_event_flags == 8'h00;
  endproperty
  a_clear_flags: assert property (p_clear_flags)
    else $error("flags not zero after clear");

  property p_clear_summary; // R2
    @(posedge core_clk) disable iff (!arst_n)
      (clear_take && !any_error) |=> !status_summary_byte[EVENT_SUM_BIT];
  endproperty
  a_clear_summary: assert property (p_clear_summary)
    else $error("summary bit set after clear");

  property p_clear_errors; // R3
    @(posedge core_clk) disable iff (!arst_n)
      (clear_take && !any_error) |=> !error_pending;
  endproperty
  a_clear_errors: assert property (p_clear_errors)
    else $error("error pending after clear");

  property p_mask_write; // R4
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_take && code == SEST_CMD_MASK_WR)
      |=> event_enable_mask == $past(cmd_operand);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("mask not stored");

  property p_mask_reset; // R5
    @(posedge core_clk) disable iff (!arst_n)
      !seen_edge |-> (event_enable_mask == 8'h00);
  endproperty
  a_mask_reset: assert property (p_mask_reset)
    else $error("mask not zero after reset");

  property p_summary; // R6
    @(posedge core_clk) disable iff (!arst_n)
      status_summary_byte[EVENT_SUM_BIT] ==
      |(standard_event_flags & event_enable_mask);
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary bit disagrees with flags and mask");

  property p_mask_reply; // R7
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_take && code == SEST_CMD_MASK_RD) |-> ##2 reply_valid;
  endproperty
  a_mask_reply: assert property (p_mask_reply)
    else $error("mask reply late");

  property p_flags_reply; // R8
    @(posedge core_clk) disable iff (!arst_n)
      (cmd_take && code == SEST_CMD_FLAGS_RD) |-> ##2 reply_valid;
  endproperty
  a_flags_reply: assert property (p_flags_reply)
    else $error("flags reply late");

  property p_fixed_zero; // R9
    @(posedge core_clk) disable iff (!arst_n)
      !standard_event_flags[6] && !standard_event_flags[1];
  endproperty
  a_fixed_zero: assert property (p_fixed_zero)
    else $error("reserved flag bit set");

  property p_done_only; // R10
    @(posedge core_clk) disable iff (!arst_n)
      (event_enable_mask == 8'h01 && !standard_event_flags[OP_DONE_BIT])
      |-> !status_summary_byte[EVENT_SUM_BIT];
  endproperty
  a_done_only: assert property (p_done_only)
    else $error("summary set by a masked flag");

  property p_op_done; // R11
    @(posedge core_clk) disable iff (!arst_n)
      (state == SEST_ST_WAIT && !op_busy)
      |=> standard_event_flags[OP_DONE_BIT] && cmd_ready;
  endproperty
  a_op_done: assert property (p_op_done)
    else $error("done flag not set after operation");

  c_clear: cover property (@(posedge core_clk) disable iff (!arst_n)
    clear_take);
  c_mask_query: cover property (@(posedge core_clk) disable iff (!arst_n)
    cmd_take && code == SEST_CMD_MASK_RD);
  c_op_done: cover property (@(posedge core_clk) disable iff (!arst_n)
    op_done_set && event_enable_mask[OP_DONE_BIT]);

endmodule // sest_regs

// ---- hw/standard_event_flags_pkg.sv ----
// Purpose: shared constants and types for the standard event status bank
// Assumes: commands arrive already parsed as a code plus an 8-bit operand
// Notes:   replies leave as ascii bytes, decimal digits then cr and lf
package sest_pkg;

  // flag positions inside standard_event_flags
  localparam int unsigned POWER_ON_BIT   = 7;
  localparam int unsigned CMD_ERR_BIT    = 5;
  localparam int unsigned EXEC_ERR_BIT   = 4;
  localparam int unsigned DEV_ERR_BIT    = 3;
  localparam int unsigned QUERY_ERR_BIT  = 2;
  localparam int unsigned OP_DONE_BIT    = 0;
  // event summary position inside status_summary_byte
  localparam int unsigned EVENT_SUM_BIT  = 5;

  // reset values
  localparam logic [7:0] MASK_RESET      = 8'h00;
  localparam logic [7:0] FLAGS_RESET     = 8'h80;  // power-on flag set
  localparam logic [7:0] FLAGS_LIVE_BITS = 8'hBD;  // bits 6 and 1 stay zero

  // reply characters
  localparam logic [7:0] ASCII_ZERO      = 8'h30;
  localparam logic [7:0] ASCII_CR        = 8'h0D;
  localparam logic [7:0] ASCII_LF        = 8'h0A;
  localparam logic [2:0] REPLY_LEN_ONE   = 3'h3;
  localparam logic [2:0] REPLY_LEN_TWO   = 3'h4;
  localparam logic [2:0] REPLY_LEN_THREE = 3'h5;

  // parsed commands
  typedef enum logic [2:0] {
    SEST_CMD_NONE     = 3'b000,
    SEST_CMD_CLEAR    = 3'b001,
    SEST_CMD_MASK_WR  = 3'b010,
    SEST_CMD_MASK_RD  = 3'b011,
    SEST_CMD_FLAGS_RD = 3'b100,
    SEST_CMD_OP_DONE  = 3'b101
  } sest_cmd_t;

  // command sequencer states
  typedef enum logic [1:0] {
    SEST_ST_IDLE  = 2'b00,
    SEST_ST_REPLY = 2'b01,
    SEST_ST_WAIT  = 2'b10
  } sest_state_t;

endpackage

// ---- hw/standard_event_flags_fmt_if.sv ----
// Purpose: carries a value to the decimal formatter and bytes back out
// Assumes: one clock domain, start is a one-cycle pulse
// Notes:   out_valid doubles as the formatter busy indication
`timescale 1ns/1ps
interface sest_fmt_if;
  logic       start;
  logic [7:0] value;
  logic       out_valid;
  logic [7:0] out_data;
  logic       out_ready;

  modport seq (output start, output value, input out_valid,
               input out_data, output out_ready);
  modport fmt (input start, input value, output out_valid,
               output out_data, input out_ready);
endinterface

// ---- hw/standard_event_flags_dec_fmt.sv ----
// Purpose: turns an 8-bit value into 1 to 3 decimal digits plus cr lf
// Assumes: start only while out_valid is low
// Notes:   bytes leave from flops; no leading zeros are sent
`timescale 1ns/1ps
module sest_dec_fmt
  import sest_pkg::*;
(
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  sest_fmt_if.fmt    fmt
);

  logic [7:0]  hundreds;
  logic [7:0]  tens;
  logic [7:0]  units;
  logic [31:0] rest;       // bytes still to send after the first
  logic [2:0]  remain;     // bytes left including the one on out_data
  logic [7:0]  next_first;
  logic [31:0] next_rest;
  logic [2:0]  next_len;

  // digit split by constant division, cheap for an 8-bit value
  always_comb begin
    hundreds = ASCII_ZERO + 8'(fmt.value / 8'd100);
    tens     = ASCII_ZERO + 8'((fmt.value / 8'd10) % 8'd10);
    units    = ASCII_ZERO + 8'(fmt.value % 8'd10);
    if (fmt.value >= 8'd100) begin
      next_first = hundreds;
      next_rest  = {tens, units, ASCII_CR, ASCII_LF};
      next_len   = REPLY_LEN_THREE;
    end else if (fmt.value >= 8'd10) begin
      next_first = tens;
      next_rest  = {units, ASCII_CR, ASCII_LF, 8'h00};
      next_len   = REPLY_LEN_TWO;
    end else begin
      next_first = units;
      next_rest  = {ASCII_CR, ASCII_LF, 16'h0000};
      next_len   = REPLY_LEN_ONE;
    end
  end

  // byte shifter, advances on each accepted byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fmt.out_valid <= 1'b0;
      fmt.out_data  <= 8'h00;
      rest          <= 32'h0000_0000;
      remain        <= 3'h0;
    end else if (fmt.start && !fmt.out_valid) begin
      fmt.out_valid <= 1'b1;
      fmt.out_data  <= next_first;
      rest          <= next_rest;
      remain        <= next_len;
    end else if (fmt.out_valid && fmt.out_ready) begin
      fmt.out_valid <= (remain != 3'h1);
      fmt.out_data  <= rest[31:24];
      rest          <= {rest[23:0], 8'h00};
      remain        <= remain - 3'h1;
    end
  end

endmodule // sest_dec_fmt

// ---- tb/standard_event_flags_host_model.sv ----
// Purpose: remote host side that sinks reply bytes from the bank
// Assumes: one clock, replies arrive as ascii bytes ending in lf
// Notes:   stall makes the host take a byte only every other cycle
`timescale 1ns/1ps
module sest_host_model (
  input  wire logic       core_clk,
  input  wire logic       arst_n,
  input  wire logic       stall,
  input  wire logic       reply_valid,
  input  wire logic [7:0] reply_data,
  output logic            reply_ready,
  output logic            got,
  output logic [7:0]      got_data
);
  // ready toggles while stalling, to hold bytes across back-pressure
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_ready <= 1'b1;
    end else begin
      reply_ready <= stall ? ~reply_ready : 1'b1;
    end
  end

  // report each byte taken; one cycle late, which the bench tolerates
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      got      <= 1'b0;
      got_data <= 8'h00;
    end else begin
      got      <= reply_valid && reply_ready;
      got_data <= reply_data;
    end
  end
endmodule // sest_host_model

// ---- tb/standard_event_status_regs_tb.sv ----
// Purpose: self-checking bench for the event flags and mask bank
// Assumes: host model sinks replies; commands are driven by tasks
// Notes:   send_cmd, query and pulse return just after a rising edge
`timescale 1ns/1ps
module standard_event_status_regs_tb
  import sest_pkg::*;
;
  logic       core_clk;
  logic       arst_n;
  logic       cmd_valid;
  logic [2:0] cmd_code;
  logic [7:0] cmd_operand;
  logic       cmd_ready;
  logic [3:0] err_ev;
  logic       op_busy;
  logic       stall;
  logic       reply_valid;
  logic [7:0] reply_data;
  logic       reply_ready;
  logic       got;
  logic [7:0] got_data;
  logic [7:0] mask;
  logic [7:0] flags;
  logic [7:0] summary;
  logic       err_pend;
  logic [7:0] rx[$];
  int         mismatches;
  int         cmp_count;
  logic [7:0] err_exp[4] = '{8'h20, 8'h10, 8'h08, 8'h04};

  sest_regs u_dut (
    .core_clk            (core_clk),
    .arst_n              (arst_n),
    .cmd_valid           (cmd_valid),
    .cmd_code            (cmd_code),
    .cmd_operand         (cmd_operand),
    .cmd_ready           (cmd_ready),
    .cmd_err_event       (err_ev[0]),
    .exec_err_event      (err_ev[1]),
    .dev_err_event       (err_ev[2]),
    .query_err_event     (err_ev[3]),
    .op_busy             (op_busy),
    .reply_valid         (reply_valid),
    .reply_data          (reply_data),
    .reply_ready         (reply_ready),
    .event_enable_mask   (mask),
    .standard_event_flags(flags),
    .status_summary_byte (summary),
    .error_pending       (err_pend)
  );

  sest_host_model u_host (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .stall      (stall),
    .reply_valid(reply_valid),
    .reply_data (reply_data),
    .reply_ready(reply_ready),
    .got        (got),
    .got_data   (got_data)
  );

  // 40 mhz clock
  always #12.5 core_clk = ~core_clk;

  // collect reply bytes seen by the host
  always @(posedge core_clk) begin
    if (got) begin
      rx.push_back(got_data);
    end
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e,
                     input string what);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: %s got %h exp %h", $time, what, g, e);
    end
  endtask

  // hold the command until cmd_ready is seen high at an edge
  task automatic send_cmd(input logic [2:0] code, input logic [7:0] opnd);
    bit rdy;
    int n;
    rdy = 0;
    n = 0;
    cmd_valid   <= 1'b1;
    cmd_code    <= code;
    cmd_operand <= opnd;
    while (!rdy && n < 100) begin
      @(negedge core_clk);
      rdy = (cmd_ready === 1'b1);
      n++;
      @(posedge core_clk);
    end
    cmd_valid <= 1'b0;
    if (!rdy) chk(8'h00, 8'h01, "command never taken");
    @(posedge core_clk);
  endtask

  // query and compare the decimal text plus cr lf
  task automatic query(input logic [2:0] code, input int v);
    string s;
    int n;
    s = $sformatf("%0d\r\n", v);
    n = 0;
    rx.delete();
    send_cmd(code, 8'h00);
    while (rx.size() < s.len() && n < 200) begin
      @(negedge core_clk);
      n++;
    end
    chk(8'(rx.size()), 8'(s.len()), "reply length");
    for (int i = 0; i < s.len() && i < rx.size(); i++) begin
      chk(rx[i], 8'(s[i]), "reply byte");
    end
    @(posedge core_clk);
  endtask

  // one-cycle error pulse on one event input
  task automatic pulse(input int i);
    err_ev[i] <= 1'b1;
    @(posedge core_clk);
    err_ev <= 4'h0;
  endtask

  task automatic end_of_test;
    $display("mismatches=%0d cmp_count=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (5000) @(posedge core_clk);
    mismatches++;
    end_of_test();
  end

  initial begin
    core_clk = 0; arst_n = 0; cmd_valid = 0; cmd_code = 0;
    cmd_operand = 0; err_ev = 0; op_busy = 0; stall = 0;
    mismatches = 0; cmp_count = 0;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    @(negedge core_clk);
    chk(mask, 8'h00, "mask at reset");
    chk(flags, 8'h80, "flags at reset");
    chk(summary, 8'h00, "summary at reset");
    @(posedge core_clk);
    query(SEST_CMD_FLAGS_RD, 128);
    query(SEST_CMD_MASK_RD, 0);
    send_cmd(SEST_CMD_MASK_WR, 8'h01);
    query(SEST_CMD_MASK_RD, 1);
    // done flag must wait for the running operation
    op_busy <= 1'b1;
    send_cmd(SEST_CMD_OP_DONE, 8'h00);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    chk(flags, 8'h80, "done flag early");
    chk({7'h00, cmd_ready}, 8'h00, "ready while busy");
    @(posedge core_clk);
    op_busy <= 1'b0;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk(flags, 8'h81, "done flag");
    chk(summary, 8'h20, "summary from done");
    @(posedge core_clk);
    query(SEST_CMD_FLAGS_RD, 129);
    send_cmd(SEST_CMD_CLEAR, 8'h00);
    @(negedge core_clk);
    chk(flags, 8'h00, "flags after clear");
    chk(summary, 8'h00, "summary after clear");
    @(posedge core_clk);
    send_cmd(SEST_CMD_MASK_WR, 8'hFF);
    // each error input lands on its own flag position
    for (int i = 0; i < 4; i++) begin
      pulse(i);
      @(negedge core_clk);
      chk(flags, err_exp[i], "error flag");
      chk(summary, 8'h20, "summary from error");
      chk({7'h00, err_pend}, 8'h01, "error held");
      @(posedge core_clk);
      send_cmd(SEST_CMD_CLEAR, 8'h00);
      @(negedge core_clk);
      chk(flags, 8'h00, "flags cleared");
      chk({7'h00, err_pend}, 8'h00, "errors discarded");
      chk(summary, 8'h00, "summary cleared");
      @(posedge core_clk);
    end
    stall <= 1'b1;
    query(SEST_CMD_MASK_RD, 255);
    stall <= 1'b0;
    send_cmd(SEST_CMD_MASK_WR, 8'h01);
    pulse(0);
    @(negedge core_clk);
    chk(summary, 8'h00, "masked event summary");
    @(posedge core_clk);
    query(SEST_CMD_FLAGS_RD, 32);
    end_of_test();
  end
endmodule // standard_event_status_regs_tb
